// File: rtl/smsp_pkg.sv
package smsp_pkg;
  localparam logic [7:0]  IDLE_BYTE      = 8'hff;
  localparam logic [5:0]  FF_SUSPEND_CNT = 6'h32;
  localparam logic [2:0]  LAST_BIT       = 3'h7;
  localparam logic [2:0]  FIRST_BIT      = 3'h0;
  localparam int          TX_BUF_DEPTH   = 2;
  localparam int          RX_BUF_DEPTH   = 2;
  localparam int          BYTE_W         = 8;
  localparam int          THR_W          = 12;
  localparam int          QCNT_W         = 13;
  localparam int          PIN_W          = 4;
  localparam int          PIN_NUM        = 16;
  localparam logic [3:0]  PIN_LIMIT      = 4'hc;
  localparam logic [12:0] EXT_IDLE_BYTES = 13'h1000;
  localparam int          CLK_HZ         = 20000000;
  localparam int          TIMEOUT_MS     = 2000;
  localparam int          TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int          TMO_W          = 26;
  localparam int          SYNC_W         = 5;
  localparam logic [4:0]  SYNC_RST       = 5'h1f;
  localparam logic [11:0] THR_RST        = 12'h000;
  localparam logic [3:0]  PIN_RST        = 4'h0;
  typedef enum logic {SMSP_IDLE, SMSP_XFER} smsp_state_t;
endpackage

// File: rtl/smsp_buf.sv
`timescale 1ns/1ps
`default_nettype none
module smsp_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = cnt_r != (AW+1)'(DEPTH);
    out_valid = cnt_r != '0;
    out_data  = mem_r[rp_r];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: rtl/smsp_port.sv
// Behaviour
// - select low gives SPI on the four pins; high gives UART plus I2C.
// - SPI is peripheral only; host drives clock and chip select.
// - no register mode; only the message byte stream in and out.
// - stop parsing after 50 consecutive 0xFF; resume on first other byte.
// - with nothing pending the data output sends 0xFF.
// - every byte in is exchanged with one byte out at once.
// - written bytes are only incoming protocol messages.
// - output bytes continue the queue, then 0xFF when empty.
// - indicator goes active at threshold, holds until queue drained.
// - up to 2 bytes may still wait in the transmit buffer after indicator drops.
// - indicator resets disabled; polarity and threshold configurable.
// - invalid or busy indicator pin rejects config, reads back all zero.
// - idle port after 2 s without transfers, or 4 kB in extended mode.
`timescale 1ns/1ps
`default_nettype none
module smsp_port #(
  parameter int TIMEOUT_CYCLES = smsp_pkg::TIMEOUT_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        if_select,
  output logic             serial_data_out,
  output logic             serial_data_out_oe_n,
  input  wire logic        serial_data_in,
  input  wire logic        cs_n_sda,
  output logic             cs_n_sda_drv,
  output logic             cs_n_sda_oe_n,
  input  wire logic        sclk_scl,
  output logic             sclk_scl_drv,
  output logic             sclk_scl_oe_n,
  input  wire logic        first_uart_port_txd,
  output logic             first_uart_port_rxd,
  input  wire logic        sda_pull_low,
  output logic             sda_level,
  output logic             scl_level,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [7:0]  rx_data,
  output logic             rx_overrun,
  input  wire logic        rx_overrun_clr,
  output logic             parse_active,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_enable,
  input  wire logic        cfg_active_high,
  input  wire logic [11:0] cfg_threshold,
  input  wire logic [3:0]  cfg_pin,
  input  wire logic [15:0] pin_busy,
  output logic             ind_enable,
  output logic             ind_active_high,
  output logic      [11:0] ind_threshold,
  output logic      [3:0]  ind_pin,
  output logic             pending_ind,
  input  wire logic [12:0] queue_count,
  input  wire logic        ext_timeout,
  output logic             port_idle
);
  // pin synchronisers: {select, data in, cs/sda, clk/scl, spare}
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       clk_prev_r;
  logic       spi_mode;
  logic       cs_act;
  logic       sdi_s;
  logic       spi_rise;
  logic       spi_fall;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r     <= smsp_pkg::SYNC_RST;
      sync_r     <= smsp_pkg::SYNC_RST;
      clk_prev_r <= smsp_pkg::SYNC_RST[1];
    end else begin
      meta_r     <= {if_select, serial_data_in, cs_n_sda, sclk_scl, 1'b1};
      sync_r     <= meta_r;
      clk_prev_r <= sync_r[1];
    end
  end

  always_comb begin
    spi_mode = ~sync_r[4];
    sdi_s    = sync_r[3];
    cs_act   = spi_mode & ~sync_r[2];
    spi_rise = sync_r[1] & ~clk_prev_r;
    spi_fall = ~sync_r[1] & clk_prev_r;
  end

  // shared pin routing
  logic [7:0] tx_sh_r;
  always_comb begin
    if (spi_mode) begin
      serial_data_out      = tx_sh_r[7];
      serial_data_out_oe_n = ~cs_act;
      cs_n_sda_oe_n        = 1'b1;
    end else begin
      serial_data_out      = first_uart_port_txd;
      serial_data_out_oe_n = 1'b0;
      cs_n_sda_oe_n        = ~sda_pull_low;
    end
    cs_n_sda_drv        = 1'b0;
    sclk_scl_drv        = 1'b0;
    sclk_scl_oe_n       = 1'b1;
    first_uart_port_rxd = spi_mode | sdi_s;
    sda_level           = sync_r[2];
    scl_level           = sync_r[1];
  end

  // transmit buffer between software queue and shifter
  logic       txb_valid;
  logic       txb_pop;
  logic [7:0] txb_data;
  smsp_buf #(.WIDTH(smsp_pkg::BYTE_W), .DEPTH(smsp_pkg::TX_BUF_DEPTH))
    u_txb (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (txb_valid),
      .out_ready (txb_pop),
      .out_data  (txb_data)
    );

  // byte exchange shifter
  smsp_pkg::smsp_state_t st_r;
  smsp_pkg::smsp_state_t st_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [7:0] tx_sh_nxt;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic [7:0] rx_byte_r;
  logic [7:0] rx_byte_nxt;
  logic       rx_done_r;
  logic       rx_done_nxt;
  logic       do_load;
  // loaded byte came from the buffer; popped once its first bit goes out
  logic       ld_buf_r;
  logic       ld_buf_nxt;

  always_comb begin
    st_nxt      = st_r;
    bit_cnt_nxt = bit_cnt_r;
    tx_sh_nxt   = tx_sh_r;
    rx_sh_nxt   = rx_sh_r;
    rx_byte_nxt = rx_byte_r;
    rx_done_nxt = 1'b0;
    do_load     = 1'b0;
    ld_buf_nxt  = ld_buf_r;
    txb_pop     = 1'b0;
    case (st_r)
      smsp_pkg::SMSP_IDLE: begin
        bit_cnt_nxt = smsp_pkg::FIRST_BIT;
        if (cs_act) begin
          st_nxt  = smsp_pkg::SMSP_XFER;
          do_load = 1'b1;
        end
      end
      smsp_pkg::SMSP_XFER: begin
        if (!cs_act) begin
          st_nxt = smsp_pkg::SMSP_IDLE;
        end else begin
          if (spi_rise) begin
            rx_sh_nxt   = {rx_sh_r[6:0], sdi_s};
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == smsp_pkg::FIRST_BIT) begin
              txb_pop    = ld_buf_r;
              ld_buf_nxt = 1'b0;
            end
            if (bit_cnt_r == smsp_pkg::LAST_BIT) begin
              rx_byte_nxt = {rx_sh_r[6:0], sdi_s};
              rx_done_nxt = 1'b1;
            end
          end
          if (spi_fall) begin
            if (bit_cnt_r == smsp_pkg::FIRST_BIT) begin
              do_load = 1'b1;
            end else begin
              tx_sh_nxt = {tx_sh_r[6:0], 1'b1};
            end
          end
        end
      end
      default: st_nxt = smsp_pkg::SMSP_IDLE;
    endcase
    if (do_load) begin
      tx_sh_nxt  = txb_valid ? txb_data : smsp_pkg::IDLE_BYTE;
      ld_buf_nxt = txb_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r      <= smsp_pkg::SMSP_IDLE;
      bit_cnt_r <= smsp_pkg::FIRST_BIT;
      tx_sh_r   <= smsp_pkg::IDLE_BYTE;
      rx_sh_r   <= '0;
      rx_byte_r <= '0;
      rx_done_r <= 1'b0;
      ld_buf_r  <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      ld_buf_r  <= ld_buf_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      tx_sh_r   <= tx_sh_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_done_r <= rx_done_nxt;
    end
  end

  // idle-byte filter and receive buffer
  logic [5:0] ff_cnt_r;
  logic [5:0] ff_cnt_nxt;
  logic       fwd;
  logic       rxb_ready;
  logic       ovr_r;
  logic       ovr_nxt;

  always_comb begin
    ff_cnt_nxt = ff_cnt_r;
    fwd        = 1'b0;
    if (rx_done_r) begin
      if (rx_byte_r != smsp_pkg::IDLE_BYTE) begin
        ff_cnt_nxt = '0;
        fwd        = 1'b1;
      end else if (ff_cnt_r != smsp_pkg::FF_SUSPEND_CNT) begin
        ff_cnt_nxt = ff_cnt_r + 6'h1;
        fwd        = 1'b1;
      end
    end
    parse_active = ff_cnt_r != smsp_pkg::FF_SUSPEND_CNT;
    ovr_nxt      = (ovr_r & ~rx_overrun_clr) | (fwd & ~rxb_ready);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ff_cnt_r <= '0;
      ovr_r    <= 1'b0;
    end else begin
      ff_cnt_r <= ff_cnt_nxt;
      ovr_r    <= ovr_nxt;
    end
  end
  assign rx_overrun = ovr_r;

  smsp_buf #(.WIDTH(smsp_pkg::BYTE_W), .DEPTH(smsp_pkg::RX_BUF_DEPTH))
    u_rxb (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (fwd),
      .in_ready  (rxb_ready),
      .in_data   (rx_byte_r),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
    );

  // pending-data indicator
  logic        en_r, en_nxt, hi_r, hi_nxt, act_r, act_nxt, pin_r, pin_nxt;
  logic [11:0] thr_r;
  logic [11:0] thr_nxt;
  logic [3:0]  sel_r;
  logic [3:0]  sel_nxt;
  logic        cfg_ok;

  always_comb begin
    en_nxt  = en_r;
    hi_nxt  = hi_r;
    thr_nxt = thr_r;
    sel_nxt = sel_r;
    cfg_ok  = (cfg_pin < smsp_pkg::PIN_LIMIT) && !pin_busy[cfg_pin];
    if (cfg_wr) begin
      en_nxt  = cfg_ok & cfg_enable;
      hi_nxt  = cfg_ok & cfg_active_high;
      thr_nxt = cfg_ok ? cfg_threshold : smsp_pkg::THR_RST;
      sel_nxt = cfg_ok ? cfg_pin : smsp_pkg::PIN_RST;
    end
    act_nxt = act_r;
    if (!en_r) begin
      act_nxt = 1'b0;
    end else if (queue_count >= {1'b0, thr_r}) begin
      act_nxt = 1'b1;
    end else if (queue_count == '0) begin
      act_nxt = 1'b0;
    end
    pin_nxt = en_r & (hi_r ? act_r : ~act_r);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_r  <= 1'b0;
      hi_r  <= 1'b0;
      thr_r <= smsp_pkg::THR_RST;
      sel_r <= smsp_pkg::PIN_RST;
      act_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      en_r  <= en_nxt;
      hi_r  <= hi_nxt;
      thr_r <= thr_nxt;
      sel_r <= sel_nxt;
      act_r <= act_nxt;
      pin_r <= pin_nxt;
    end
  end

  always_comb begin
    ind_enable      = en_r;
    ind_active_high = hi_r;
    ind_threshold   = thr_r;
    ind_pin         = sel_r;
    pending_ind     = pin_r;
  end

  // transfer timeout
  logic [25:0] tmo_r;
  logic [25:0] tmo_nxt;
  logic        idle_r;
  logic        idle_nxt;

  always_comb begin
    tmo_nxt  = tmo_r;
    idle_nxt = idle_r;
    if (rx_done_r) begin
      tmo_nxt  = '0;
      idle_nxt = 1'b0;
    end else if (ext_timeout) begin
      tmo_nxt  = '0;
      idle_nxt = queue_count >= smsp_pkg::EXT_IDLE_BYTES;
    end else if (tmo_r == 26'(TIMEOUT_CYCLES - 1)) begin
      idle_nxt = 1'b1;
    end else begin
      tmo_nxt = tmo_r + 26'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tmo_r  <= '0;
      idle_r <= 1'b0;
    end else begin
      tmo_r  <= tmo_nxt;
      idle_r <= idle_nxt;
    end
  end
  assign port_idle = idle_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_pin_mode;
    !spi_mode |-> !serial_data_out_oe_n && !first_uart_port_rxd == !sdi_s;
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("uart mode pin routing wrong");

  property p_peripheral;
    spi_mode && sync_r[2] |-> serial_data_out_oe_n;
  endproperty
  a_peripheral: assert property (p_peripheral)
    else $error("data out driven without chip select");

  property p_idle_byte;
    do_load && !txb_valid |=> tx_sh_r == 8'hff;
  endproperty
  a_idle_byte: assert property (p_idle_byte)
    else $error("empty queue did not load 0xff");

  property p_stream;
    do_load && txb_valid |=> tx_sh_r == $past(txb_data);
  endproperty
  a_stream: assert property (p_stream)
    else $error("queued byte not loaded");

  property p_exchange;
    st_r == smsp_pkg::SMSP_XFER && cs_act && spi_rise && bit_cnt_r == 3'h7
      |=> rx_done_r ##0 bit_cnt_r == 3'h0;
  endproperty
  a_exchange: assert property (p_exchange)
    else $error("byte not completed on eighth edge");

  property p_suspend;
    rx_done_r && rx_byte_r == 8'hff && ff_cnt_r == 6'h32 |-> !fwd;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("0xff parsed while suspended");

  property p_resume;
    rx_done_r && rx_byte_r != 8'hff |-> fwd ##1 ff_cnt_r == 6'h0 && parse_active;
  endproperty
  a_resume: assert property (p_resume)
    else $error("parsing not resumed");

  property p_ind_on;
    en_r && !act_r && queue_count >= {1'b0, thr_r} && !cfg_wr
      |=> act_r ##1 pending_ind == hi_r;
  endproperty
  a_ind_on: assert property (p_ind_on)
    else $error("indicator did not activate at threshold");

  property p_ind_hold;
    act_r && en_r && queue_count != 13'h0 && !cfg_wr |=> act_r;
  endproperty
  a_ind_hold: assert property (p_ind_hold)
    else $error("indicator dropped before queue drained");

  property p_cfg_reject;
    cfg_wr && !cfg_ok |=> !en_r && !hi_r && thr_r == 12'h0 && sel_r == 4'h0;
  endproperty
  a_cfg_reject: assert property (p_cfg_reject)
    else $error("bad indicator pin not rejected");

  property p_timeout;
    !ext_timeout && !rx_done_r && tmo_r == 26'(TIMEOUT_CYCLES - 1) |=> idle_r;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("port not idled after timeout");

  c_suspend: cover property (rx_done_r && ff_cnt_r == 6'h32);
  c_stream: cover property (txb_pop);
  c_ind: cover property (pending_ind && hi_r);
  c_idle: cover property (idle_r);
endmodule
`default_nettype wire

// File: dv/smsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smsp_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [7:0] msgq[$];
  int         half_ns = 200;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // one framed exchange of every queued byte, clock still outside frames
  task automatic frame();
    logic [7:0] t;
    logic [7:0] r;
    #13;
    cs_n = 1'b0;
    #(2 * half_ns);
    while (txq.size() > 0) begin
      t = txq.pop_front();
      for (int i = 7; i >= 0; i--) begin
        mosi = t[i];
        #(half_ns);
        sclk = 1'b1;
        r[i] = miso;
        #(half_ns);
        sclk = 1'b0;
      end
      rxq.push_back(r);
      if (r != 8'hff) msgq.push_back(r);
    end
    mosi = 1'b1;
    #(half_ns);
    cs_n = 1'b1;
    #(2 * half_ns);
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk, sys_rst, if_select, serial_data_out, sdo_oe_n;
  logic        cs_drv, cs_oe_n, sclk_drv, sclk_oe_n, uart_txd, uart_rxd;
  logic        sda_pull_low, sda_level, tx_valid, tx_ready, rx_valid;
  logic        rx_ready, rx_overrun, rx_overrun_clr, parse_active, cfg_wr;
  logic        cfg_enable, cfg_active_high, ind_enable, ind_active_high;
  logic        pending_ind, ext_timeout, port_idle, h_sclk, h_cs_n, h_mosi;
  logic        sdo_last = 1'b1;
  logic        scl_level;
  int          n_msg = 0;
  logic [7:0]  tx_data, rx_data, v;
  logic [11:0] cfg_threshold, ind_threshold, t;
  logic [3:0]  cfg_pin, ind_pin, p;
  logic [15:0] pin_busy;
  logic [12:0] queue_count;
  logic [17:0] e;
  logic [31:0] seed = 32'h3c4c;
  logic [7:0]  got[$], expq[$], txm[$], hexp[$];
  int          bad_count = 0;
  int          checks_done = 0;
  int          ff_run = 0;
  wire         p18 = h_cs_n & (cs_oe_n | cs_drv);
  wire         p19 = h_sclk & (sclk_oe_n | sclk_drv);
  wire         miso = sdo_oe_n ? ~sdo_last : serial_data_out;
  wire [17:0]  rdbk = {ind_enable, ind_active_high, ind_threshold, ind_pin};

  smsp_port #(.TIMEOUT_CYCLES(200)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .if_select(if_select),
    .serial_data_out(serial_data_out), .serial_data_out_oe_n(sdo_oe_n),
    .serial_data_in(h_mosi), .cs_n_sda(p18), .cs_n_sda_drv(cs_drv),
    .cs_n_sda_oe_n(cs_oe_n), .sclk_scl(p19), .sclk_scl_drv(sclk_drv),
    .sclk_scl_oe_n(sclk_oe_n), .first_uart_port_txd(uart_txd),
    .first_uart_port_rxd(uart_rxd), .sda_pull_low(sda_pull_low),
    .sda_level(sda_level), .scl_level(scl_level), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun),
    .rx_overrun_clr(rx_overrun_clr), .parse_active(parse_active),
    .cfg_wr(cfg_wr), .cfg_enable(cfg_enable),
    .cfg_active_high(cfg_active_high), .cfg_threshold(cfg_threshold),
    .cfg_pin(cfg_pin), .pin_busy(pin_busy), .ind_enable(ind_enable),
    .ind_active_high(ind_active_high), .ind_threshold(ind_threshold),
    .ind_pin(ind_pin), .pending_ind(pending_ind),
    .queue_count(queue_count), .ext_timeout(ext_timeout),
    .port_idle(port_idle));
  smsp_host_model u_host (.sclk(h_sclk), .cs_n(h_cs_n), .mosi(h_mosi),
    .miso(miso));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (rx_valid && rx_ready) got.push_back(rx_data);
    if (tx_valid && tx_ready) txm.push_back(tx_data);
    if (tx_valid && tx_ready && tx_data != 8'hff) n_msg++;
    if (!sdo_oe_n) sdo_last <= serial_data_out;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd(output logic [7:0] r);
    seed = lfsr(seed);
    r = seed[7:0];
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // host frame of n bytes; model predicts both directions
  task automatic xfer(input int n, input logic [7:0] b, input bit rand_on);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = b;
      if (rand_on) rnd(d);
      u_host.txq.push_back(d);
      ff_run = (d == 8'hff) ? ff_run + 1 : 0;
      if (d != 8'hff || ff_run <= 50) expq.push_back(d);
      hexp.push_back(txm.size() > 0 ? txm.pop_front() : 8'hff);
    end
    u_host.frame();
    tick(12);
  endtask

  task automatic cmp(input string nm);
    chk("rx_count", got.size(), expq.size());
    while (got.size() > 0 && expq.size() > 0) begin
      chk("rx_byte", got.pop_front(), expq.pop_front());
    end
    chk("host_count", u_host.rxq.size(), hexp.size());
    while (u_host.rxq.size() > 0 && hexp.size() > 0) begin
      chk("host_byte", u_host.rxq.pop_front(), hexp.pop_front());
    end
    got.delete();
    expq.delete();
    $display("test %s done", nm);
  endtask

  task automatic push(input logic [7:0] b);
    tx_valid <= 1'b1;
    tx_data <= b;
    do @(posedge sys_clk); while (!tx_ready);
  endtask

  task automatic cfg(input logic [11:0] thr, input logic pol,
                     input logic [3:0] pin);
    cfg_wr <= 1'b1;
    cfg_enable <= 1'b1;
    cfg_active_high <= pol;
    cfg_threshold <= thr;
    cfg_pin <= pin;
    tick(1);
    cfg_wr <= 1'b0;
    tick(2);
  endtask

  initial begin
    #2000000;
    bad_count++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    if_select = 1'b0;
    uart_txd = 1'b1;
    sda_pull_low = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b1;
    rx_overrun_clr = 1'b0;
    cfg_wr = 1'b0;
    cfg_enable = 1'b0;
    cfg_active_high = 1'b0;
    cfg_threshold = 12'h000;
    cfg_pin = 4'h0;
    pin_busy = 16'h0000;
    queue_count = 13'h0000;
    ext_timeout = 1'b0;
    tick(20);
    sys_rst <= 1'b0;
    tick(4);
    chk("pending_ind", pending_ind, 1'b0);
    chk("ind_rdbk", rdbk, 18'h0);
    chk("port_idle", port_idle, 1'b0);
    chk("sdo_oe_n", sdo_oe_n, 1'b1);
    chk("ctl_oe_n", {cs_oe_n, sclk_oe_n, uart_rxd}, 3'h7);
    $display("test reset done");
    xfer(6, 8'h00, 1);
    cmp("idle_out");
    rnd(v);
    push(v);
    rnd(v);
    push(v);
    rnd(v);
    tx_data <= v;
    tick(3);
    chk("tx_ready", tx_ready, 1'b0);
    chk("tx_fill", txm.size(), 32'd2);
    tx_valid <= 1'b0;
    u_host.half_ns = 400;
    xfer(4, 8'h00, 1);
    u_host.half_ns = 200;
    cmp("tx_stream");
    chk("host_msg", u_host.msgq.size(), n_msg);
    rx_ready <= 1'b0;
    xfer(3, 8'h00, 1);
    void'(expq.pop_back());
    chk("rx_overrun", rx_overrun, 1'b1);
    rx_ready <= 1'b1;
    tick(4);
    chk("rx_valid", rx_valid, 1'b0);
    rx_overrun_clr <= 1'b1;
    tick(1);
    rx_overrun_clr <= 1'b0;
    tick(2);
    chk("rx_overrun", rx_overrun, 1'b0);
    cmp("rx_stall");
    xfer(49, 8'hff, 0);
    chk("parse_active", parse_active, ff_run < 50);
    xfer(1, 8'hff, 0);
    chk("parse_active", parse_active, ff_run < 50);
    xfer(3, 8'hff, 0);
    xfer(1, 8'h5a, 0);
    chk("parse_active", parse_active, 1'b1);
    cmp("ff_suspend");
    for (int k = 0; k < 2; k++) begin
      rnd(v);
      t = {4'h0, v} + 12'h001;
      cfg(t, k[0], 4'h3);
      e = {1'b1, k[0], t, 4'h3};
      chk("ind_rdbk", rdbk, e);
      queue_count <= {1'b0, t} - 13'h0001;
      tick(4);
      chk("pending_ind", pending_ind, !k[0]);
      queue_count <= {1'b0, t};
      tick(3);
      chk("pending_ind", pending_ind, k[0]);
      queue_count <= 13'h0001;
      tick(3);
      chk("pending_ind", pending_ind, k[0]);
      queue_count <= 13'h0000;
      tick(3);
      chk("pending_ind", pending_ind, !k[0]);
    end
    pin_busy <= 16'h0020;
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 4'hb : (k == 1) ? 4'hc : 4'h5;
      cfg(12'h010, 1'b1, p);
      e = (k == 0) ? {2'b11, 12'h010, p} : 18'h0;
      chk("ind_rdbk", rdbk, e);
    end
    $display("test indicator done");
    xfer(1, 8'h11, 0);
    tick(150);
    chk("port_idle", port_idle, 1'b0);
    tick(60);
    chk("port_idle", port_idle, 1'b1);
    ext_timeout <= 1'b1;
    queue_count <= 13'h0fff;
    tick(3);
    chk("port_idle", port_idle, 1'b0);
    queue_count <= 13'h1000;
    tick(3);
    chk("port_idle", port_idle, 1'b1);
    ext_timeout <= 1'b0;
    queue_count <= 13'h0000;
    xfer(1, 8'h22, 0);
    chk("port_idle", port_idle, 1'b0);
    cmp("timeout");
    if_select <= 1'b1;
    sda_pull_low <= 1'b1;
    u_host.mosi <= 1'b0;
    tick(4);
    for (int k = 0; k < 4; k++) begin
      rnd(v);
      uart_txd <= v[0];
      tick(1);
      chk("uart_txd", serial_data_out, v[0]);
    end
    chk("sdo_oe_n", sdo_oe_n, 1'b0);
    chk("uart_rxd", uart_rxd, 1'b0);
    chk("sda_oe_n", cs_oe_n, 1'b0);
    chk("sda_level", sda_level, 1'b0);
    chk("scl_level", scl_level, 1'b0);
    $display("test uart_mode done");
    test_done();
  end
endmodule
`default_nettype wire
